/* hdl/flsp_top.v */
/*
 * Fault indicator drivers for sixteen serial ATA lanes plus a global
 * fault, and the function select for sideband pads 15 down to 8
 * (SGPIO channels 2 and 3, or two-wire buses 3 and 4).
 * Assumes lane status and the pads arrive asynchronously to clk_i,
 * that the config word comes from core logic on clk_i, and that the
 * pad cell resolves the wire from output, enable and pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
`include "flsp_defines.vh"

// Operation
// - Fault outputs are active low; a low pad lights the indicator.
// - Lane faults while not ready; when ready, only on PHY or link error.
// - Indicator bits 7:0 follow lanes 7:0, bits 15:8 follow lanes 15:8.
// - Indicator bit 16 is the global fault, lit when any lane faults.
// - Config bit 9 alone selects the function of every muxed pad.
// - Select one: pads 15,14,13,12 are channel 3 SCLK, SLOAD, SDOUT, SDIN.
// - Select zero: pads 15 and 14 carry clock and data of bus four.
// - Select one: pads 11,10,9 are channel 2 SCLK, SLOAD, SDOUT.
// - Select zero: pads 11 and 10 carry clock and data of bus three.
// - Select zero: pads 13, 12 and 9 are inputs whose values are ignored.
// - Pad 8 is channel 2 SDIN when select is one, else an unused input.
module flsp_top #(
  parameter LANES = `FLSP_LANES
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             reset_i,
  // Lane status from the PHYs
  input  wire [LANES-1:0] phy_ready_i,
  input  wire [LANES-1:0] phy_error_i,
  input  wire [LANES-1:0] conn_error_i,
  // Configuration word holding the pad function select
  input  wire [31:0]      config_word_i,
  // Fault indicator pads, active low
  output reg  [LANES:0]   fault_indicator_n_o,
  // Sideband pads 15..8, index 0 is pad 8
  input  wire [7:0]       sideband_serial_pad_in_i,
  output reg  [7:0]       sideband_serial_pad_out_o,
  output reg  [7:0]       sideband_serial_pad_oe_n_o,
  // SGPIO channel 2 core side
  input  wire             sgpio2_sclk_i,
  input  wire             sgpio2_sload_i,
  input  wire             sgpio2_sdout_i,
  output reg              sgpio2_sdin_o,
  // SGPIO channel 3 core side
  input  wire             sgpio3_sclk_i,
  input  wire             sgpio3_sload_i,
  input  wire             sgpio3_sdout_i,
  output reg              sgpio3_sdin_o,
  // Two-wire bus 3 core side, open drain: drive low when *_low_i
  input  wire             twb3_scl_low_i,
  input  wire             twb3_sda_low_i,
  output reg              twb3_scl_o,
  output reg              twb3_sda_o,
  // Two-wire bus 4 core side
  input  wire             twb4_scl_low_i,
  input  wire             twb4_sda_low_i,
  output reg              twb4_scl_o,
  output reg              twb4_sda_o,
  // Current pad function, for observation
  output reg              pad_function_select_o
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************

  wire [LANES-1:0] ready_s;
  wire [LANES-1:0] phy_err_s;
  wire [LANES-1:0] conn_err_s;
  wire [7:0]       pad_in_s;

  // Lane status may come from the PHY clocks, so resynchronise
  flsp_sync2 #(.WIDTH(3*LANES)) u_lane_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({phy_ready_i, phy_error_i, conn_error_i}),
    .q_o     ({ready_s, phy_err_s, conn_err_s})
  );

  // Pad receivers are asynchronous to the core clock
  flsp_sync2 #(.WIDTH(8)) u_pad_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     (sideband_serial_pad_in_i),
    .q_o     (pad_in_s)
  );

  // ****************************************************************
  // Fault indicators
  // ****************************************************************

  wire [LANES-1:0] lane_fault;
  wire             any_fault;

  flsp_fault_map #(.LANES(LANES)) u_fault (
    .phy_ready_i  (ready_s),
    .phy_error_i  (phy_err_s),
    .conn_error_i (conn_err_s),
    .lane_fault_o (lane_fault),
    .any_fault_o  (any_fault)
  );

  // Registered, inverted; lane n drives bit n directly. Reset shows
  // all indicators dark; for two cycles after it they light, as the syncs read not ready.
  always @(posedge clk_i) begin
    if (reset_i) begin
      fault_indicator_n_o <= `FLSP_FAULT_OFF;
    end else begin
      fault_indicator_n_o[LANES-1:0] <= ~lane_fault;
      fault_indicator_n_o[LANES]     <= ~any_fault;
    end
  end

  // ****************************************************************
  // Pad function select
  // ****************************************************************

  wire sel_now;

  // Single bit steers all muxed pads; core-side word, no sync needed
  assign sel_now = config_word_i[`FLSP_SEL_BIT];

  always @(posedge clk_i) begin
    if (reset_i) begin
      pad_function_select_o <= `FLSP_SEL_RESET;
    end else begin
      pad_function_select_o <= sel_now;
    end
  end

  // ****************************************************************
  // Pad drive
  // ****************************************************************

  reg [7:0] pad_out_next;
  reg [7:0] pad_oe_n_next;

  // Output enable low means drive. Two-wire lines only ever pull low,
  // so their data is zero and the enable carries the bit.
  always @* begin
    pad_out_next  = 8'h00;
    pad_oe_n_next = 8'hff;
    if (sel_now) begin
      pad_out_next[`FLSP_PAD_CH3_SCLK]   = sgpio3_sclk_i;
      pad_out_next[`FLSP_PAD_CH3_SLOAD]  = sgpio3_sload_i;
      pad_out_next[`FLSP_PAD_CH3_SDOUT]  = sgpio3_sdout_i;
      pad_oe_n_next[`FLSP_PAD_CH3_SCLK]  = 1'b0;
      pad_oe_n_next[`FLSP_PAD_CH3_SLOAD] = 1'b0;
      pad_oe_n_next[`FLSP_PAD_CH3_SDOUT] = 1'b0;
      pad_out_next[`FLSP_PAD_CH2_SCLK]   = sgpio2_sclk_i;
      pad_out_next[`FLSP_PAD_CH2_SLOAD]  = sgpio2_sload_i;
      pad_out_next[`FLSP_PAD_CH2_SDOUT]  = sgpio2_sdout_i;
      pad_oe_n_next[`FLSP_PAD_CH2_SCLK]  = 1'b0;
      pad_oe_n_next[`FLSP_PAD_CH2_SLOAD] = 1'b0;
      pad_oe_n_next[`FLSP_PAD_CH2_SDOUT] = 1'b0;
    end else begin
      pad_oe_n_next[`FLSP_PAD_CH3_SCLK]  = ~twb4_scl_low_i;
      pad_oe_n_next[`FLSP_PAD_CH3_SLOAD] = ~twb4_sda_low_i;
      pad_oe_n_next[`FLSP_PAD_CH2_SCLK]  = ~twb3_scl_low_i;
      pad_oe_n_next[`FLSP_PAD_CH2_SLOAD] = ~twb3_sda_low_i;
    end
  end

  // Registered so pad outputs come straight from flops
  always @(posedge clk_i) begin
    if (reset_i) begin
      sideband_serial_pad_out_o  <= `FLSP_PAD_OUT_RESET;
      sideband_serial_pad_oe_n_o <= `FLSP_PAD_OE_RESET;
    end else begin
      sideband_serial_pad_out_o  <= pad_out_next;
      sideband_serial_pad_oe_n_o <= pad_oe_n_next;
    end
  end

  // ****************************************************************
  // Receive paths
  // ****************************************************************

  // Inputs not selected read idle: SDIN low, two-wire lines high.
  // Pads 13, 12, 9 and 8 are ignored when select is zero.
  always @(posedge clk_i) begin
    if (reset_i) begin
      sgpio2_sdin_o <= `FLSP_SDIN_RESET;
      sgpio3_sdin_o <= `FLSP_SDIN_RESET;
      twb3_scl_o    <= `FLSP_TWB_RESET;
      twb3_sda_o    <= `FLSP_TWB_RESET;
      twb4_scl_o    <= `FLSP_TWB_RESET;
      twb4_sda_o    <= `FLSP_TWB_RESET;
    end else begin
      sgpio3_sdin_o <= sel_now & pad_in_s[`FLSP_PAD_CH3_SDIN];
      sgpio2_sdin_o <= sel_now & pad_in_s[`FLSP_PAD_CH2_SDIN];
      twb4_scl_o    <= sel_now | pad_in_s[`FLSP_PAD_CH3_SCLK];
      twb4_sda_o    <= sel_now | pad_in_s[`FLSP_PAD_CH3_SLOAD];
      twb3_scl_o    <= sel_now | pad_in_s[`FLSP_PAD_CH2_SCLK];
      twb3_sda_o    <= sel_now | pad_in_s[`FLSP_PAD_CH2_SLOAD];
    end
  end

endmodule // flsp_top

`default_nettype wire

/* hdl/flsp_defines.vh */
/*
 * Constants for the fault indicator and sideband pad select block:
 * lane counts, pad positions, select bit position and reset values.
 * Assumes it is included by bare name from the design files.
 */
`ifndef FLSP_DEFINES_VH
`define FLSP_DEFINES_VH

// ****************************************************************
// Widths
// ****************************************************************
`define FLSP_LANES          16
`define FLSP_FAULT_W        17
`define FLSP_GLOBAL_BIT     16
`define FLSP_PAD_W          8
`define FLSP_CFG_W          32

// ****************************************************************
// Select field and reset values
// ****************************************************************
`define FLSP_SEL_BIT        9
`define FLSP_CFG_RESET      32'h0000_0000
`define FLSP_FAULT_OFF      17'h1_ffff
`define FLSP_PAD_OUT_RESET  8'h00
`define FLSP_PAD_OE_RESET   8'hff
`define FLSP_SEL_RESET      1'b0
`define FLSP_SDIN_RESET     1'b0
`define FLSP_TWB_RESET      1'b1

// ****************************************************************
// Pad positions inside the upper pad group (pad 8 is index 0)
// ****************************************************************
`define FLSP_PAD_CH2_SDIN   0
`define FLSP_PAD_CH2_SDOUT  1
`define FLSP_PAD_CH2_SLOAD  2
`define FLSP_PAD_CH2_SCLK   3
`define FLSP_PAD_CH3_SDIN   4
`define FLSP_PAD_CH3_SDOUT  5
`define FLSP_PAD_CH3_SLOAD  6
`define FLSP_PAD_CH3_SCLK   7

`endif

/* hdl/flsp_sync2.v */
/*
 * Two-flop synchroniser, one bit per lane of a vector.
 * Assumes the destination clock is clk_i and reset is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module flsp_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             reset_i,
  // Data
  input  wire [WIDTH-1:0] d_i,
  output wire [WIDTH-1:0] q_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // First stage is read only by the second stage
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule // flsp_sync2

`default_nettype wire

/* hdl/flsp_fault_map.v */
/*
 * Per-lane fault decision and global fault reduction, combinational.
 * Assumes its inputs are already in the clk_i domain.
 */
`timescale 1ns/1ps
`default_nettype none

module flsp_fault_map #(
  parameter LANES = 16
) (
  // Lane status
  input  wire [LANES-1:0] phy_ready_i,
  input  wire [LANES-1:0] phy_error_i,
  input  wire [LANES-1:0] conn_error_i,
  // Fault result, active high
  output wire [LANES-1:0] lane_fault_o,
  output wire             any_fault_o
);

  // Not ready always faults; once ready only errors fault
  assign lane_fault_o = ~phy_ready_i | (phy_ready_i & (phy_error_i | conn_error_i));

  // Global fault is any lane fault
  assign any_fault_o = |lane_fault_o;

endmodule // flsp_fault_map

`default_nettype wire

/* tb/flsp_monitor.sv */
/* Port checker for flsp_top: lamp timing and pad muxing.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module flsp_monitor #(parameter LANES = 16) (
  input wire logic             clk_i, reset_i, pad_function_select_o,
  input wire logic [LANES-1:0] phy_ready_i, phy_error_i, conn_error_i,
  input wire logic [31:0]      config_word_i,
  input wire logic [LANES:0]   fault_indicator_n_o,
  input wire logic [7:0]       sideband_serial_pad_in_i, sideband_serial_pad_out_o,
  input wire logic [7:0]       sideband_serial_pad_oe_n_o,
  input wire logic             sgpio2_sclk_i, sgpio2_sload_i, sgpio2_sdout_i,
  input wire logic             sgpio3_sclk_i, sgpio3_sload_i, sgpio3_sdout_i,
  input wire logic             sgpio3_sdin_o, twb4_scl_o, twb3_sda_low_i, twb4_scl_low_i
);
  // ****************
  // Helpers
  // ****************
  wire logic [LANES:0]   fn = fault_indicator_n_o;
  wire logic [7:0]       oe = sideband_serial_pad_oe_n_o;
  wire logic [7:0]       po = sideband_serial_pad_out_o;
  wire logic [7:0]       pin = sideband_serial_pad_in_i;
  wire logic             sel = pad_function_select_o;
  wire logic [2:0]       ch3 = {sgpio3_sclk_i, sgpio3_sload_i, sgpio3_sdout_i};
  wire logic [2:0]       ch2 = {sgpio2_sclk_i, sgpio2_sload_i, sgpio2_sdout_i};
  wire logic [LANES-1:0] bad = ~phy_ready_i | phy_error_i | conn_error_i;
  logic [2:0]            warm_reg;
  // Edges since reset; syncs hold stale data until three have passed
  always_ff @(posedge clk_i) begin
    if (reset_i) warm_reg <= 3'h0;
    else if (!warm_reg[2]) warm_reg <= warm_reg + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_lane0_drop;
    $fell(phy_ready_i[0]) ##1 !phy_ready_i[0] [*2];
  endsequence
  a_reset_dark: assert property ($past(reset_i) |-> &fn && &oe && !po && !sel)
    else $error("outputs not idle after reset");
  a_lane_map: assert property (warm_reg[2] |-> fn[LANES-1:0] == ~$past(bad, 3))
    else $error("lane lamp wrong");
  a_global_fault: assert property (warm_reg[2] |-> fn[LANES] == ~|$past(bad, 3))
    else $error("global lamp wrong");
  a_drop_lit: assert property (s_lane0_drop |=> !fn[0] && !fn[LANES])
    else $error("lamp dark after drop");
  a_sel_copy: assert property (warm_reg != 3'h0 |-> sel == $past(config_word_i[9]))
    else $error("select not bit 9");
  a_ch3_drive: assert property (sel |-> oe[7:5] == 3'h0 && po[7:5] == $past(ch3))
    else $error("channel 3 pads wrong");
  a_ch2_drive: assert property (sel |-> oe[3:1] == 3'h0 && po[3:1] == $past(ch2))
    else $error("channel 2 pads wrong");
  a_twb_drive: assert property (warm_reg != 3'h0 && !sel |-> po == 8'h00 &&
    oe[7] == !$past(twb4_scl_low_i) && oe[2] == !$past(twb3_sda_low_i))
    else $error("two-wire drive wrong");
  a_unused_in: assert property (oe[4] && oe[0] && (sel || oe[5] && oe[1]))
    else $error("input pad driven");
  a_sdin_recv: assert property (warm_reg[2] |-> sgpio3_sdin_o == (sel && $past(pin[4], 3)))
    else $error("sdin wrong");
  a_twb_recv: assert property (warm_reg[2] |-> twb4_scl_o == (sel || $past(pin[7], 3)))
    else $error("two-wire read wrong");
endmodule // flsp_monitor

bind flsp_top flsp_monitor #(.LANES(LANES)) mon_u (.clk_i, .reset_i, .pad_function_select_o,
  .phy_ready_i, .phy_error_i, .conn_error_i, .config_word_i, .fault_indicator_n_o,
  .sideband_serial_pad_in_i, .sideband_serial_pad_out_o, .sideband_serial_pad_oe_n_o,
  .sgpio2_sclk_i, .sgpio2_sload_i, .sgpio2_sdout_i, .sgpio3_sclk_i, .sgpio3_sload_i,
  .sgpio3_sdout_i, .sgpio3_sdin_o, .twb4_scl_o, .twb3_sda_low_i, .twb4_scl_low_i);
`default_nettype wire

/* tb/flsp_far_model.sv */
/* Far side: lamps and sideband peripherals on pads 15..8.
   Assumes pull-ups on every sideband pad. */
`timescale 1ns/1ps
`default_nettype none
module flsp_far_model (
  // Design pads
  input  wire logic [16:0] fault_n_i,
  input  wire logic [7:0]  pad_out_i,
  input  wire logic [7:0]  pad_oe_n_i,
  // Peripheral pulls, high holds the line low
  input  wire logic [7:0]  pull_low_i,
  // Lamp state and resolved wires
  output wire logic [16:0] lit_o,
  output wire logic [7:0]  wire_o
);
  // ****************
  // Wires
  // ****************
  // Lamp glows while its pad is low
  assign lit_o = ~fault_n_i;
  // Undriven pads float high; any low wins, so no stale level shows
  assign wire_o = (~pad_oe_n_i & pad_out_i | pad_oe_n_i) & ~pull_low_i;
endmodule // flsp_far_model
`default_nettype wire

/* tb/flsp_top_tb.sv */
/* Bench for flsp_top: fault lamps and pad select.
   Assumes flsp_monitor is bound and flsp_far_model sits on the pads. */
`timescale 1ns/1ps
`default_nettype none
module flsp_top_tb;
  // ****************
  // Signals
  // ****************
  logic        clk_i, reset_i, pad_function_select_o;
  logic [15:0] phy_ready_i, phy_error_i, conn_error_i;
  logic [31:0] config_word_i;
  logic [16:0] fault_indicator_n_o, lit;
  logic [7:0]  sideband_serial_pad_in_i, sideband_serial_pad_out_o;
  logic [7:0]  sideband_serial_pad_oe_n_o, pull;
  logic        sgpio2_sclk_i, sgpio2_sload_i, sgpio2_sdout_i, sgpio2_sdin_o;
  logic        sgpio3_sclk_i, sgpio3_sload_i, sgpio3_sdout_i, sgpio3_sdin_o;
  logic        twb3_scl_low_i, twb3_sda_low_i, twb3_scl_o, twb3_sda_o;
  logic        twb4_scl_low_i, twb4_sda_low_i, twb4_scl_o, twb4_sda_o;
  int          errors, check_count;
  wire logic [7:0] oe = sideband_serial_pad_oe_n_o;
  wire logic [7:0] po = sideband_serial_pad_out_o;
  wire logic [3:0] tw = {twb4_scl_o, twb4_sda_o, twb3_scl_o, twb3_sda_o};
  flsp_top dut_u (.clk_i, .reset_i, .phy_ready_i, .phy_error_i, .conn_error_i,
    .config_word_i, .fault_indicator_n_o, .sideband_serial_pad_in_i,
    .sideband_serial_pad_out_o, .sideband_serial_pad_oe_n_o, .sgpio2_sclk_i,
    .sgpio2_sload_i, .sgpio2_sdout_i, .sgpio2_sdin_o, .sgpio3_sclk_i, .sgpio3_sload_i,
    .sgpio3_sdout_i, .sgpio3_sdin_o, .twb3_scl_low_i, .twb3_sda_low_i, .twb3_scl_o,
    .twb3_sda_o, .twb4_scl_low_i, .twb4_sda_low_i, .twb4_scl_o, .twb4_sda_o,
    .pad_function_select_o);
  flsp_far_model far_u (.fault_n_i(fault_indicator_n_o), .pad_out_i(po), .pad_oe_n_i(oe),
    .pull_low_i(pull), .lit_o(lit), .wire_o(sideband_serial_pad_in_i));
  // 250 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // One lane at a time, cycling not-ready, PHY error and link error
  task automatic t_faults;
    logic [15:0] f;
    // All lanes up first, so lane 0 going down is a real falling edge
    {phy_ready_i, phy_error_i, conn_error_i} = {16'hffff, 32'h0};
    wt(4);
    chk(fault_indicator_n_o, 17'h1_ffff);
    for (int k = 0; k < 16; k++) begin
      f = 16'h1 << k;
      phy_ready_i = (k % 3 == 0) ? ~f : 16'hffff;
      phy_error_i = (k % 3 == 1) ? f : 16'h0;
      conn_error_i = (k % 3 == 2) ? f : 16'h0;
      wt(4);
      chk(fault_indicator_n_o, {1'b0, ~f});
      chk(lit, {1'b1, f});
    end
    {phy_ready_i, phy_error_i, conn_error_i} = {16'hffff, 32'h0};
    wt(4);
    chk(fault_indicator_n_o, 17'h1_ffff);
    $display("faults done");
  endtask
  // Other config bits set against bit 9; pulls on every pad for select zero, on pads 12 and 8 only for select one
  task automatic t_sel(input logic s);
    logic [3:0] p, tl, et;
    logic [1:0] es;
    for (int i = 0; i < 16; i++) begin
      p = i[3:0];
      tl = {p[0], p[3:1]};
      config_word_i = s ? 32'h0000_0200 : 32'hffff_fdff;
      {sgpio3_sclk_i, sgpio3_sload_i, sgpio3_sdout_i} = p[2:0];
      {sgpio2_sclk_i, sgpio2_sload_i, sgpio2_sdout_i} = p[3:1];
      {twb4_scl_low_i, twb4_sda_low_i, twb3_scl_low_i, twb3_sda_low_i} = tl;
      pull = s ? {3'h0, p[0], 3'h0, p[1]} : {p, ~p};
      wt(4);
      et = s ? 4'hf : ~(tl | {pull[7:6], pull[3:2]});
      es = s ? ~{pull[4], pull[0]} : 2'h0;
      chk(pad_function_select_o, s);
      if (s) begin
        chk(oe, 8'h11);
        chk({po[7:5], po[3:1]}, {p[2:0], p[3:1]});
      end else begin
        chk(po, 8'h00);
        chk(oe, {~tl[3:2], 2'h3, ~tl[1:0], 2'h3});
      end
      chk({sgpio3_sdin_o, sgpio2_sdin_o}, es);
      chk(tw, et);
    end
    $display("select %0d done", s);
  endtask
  // Hang guard, well past the few hundred cycles the tests need
  initial begin
    #8000;
    errors++;
    close_out;
  end
  initial begin
    errors = 0;
    check_count = 0;
    reset_i = 1'b1;
    {phy_ready_i, phy_error_i, conn_error_i, config_word_i, pull} = 88'h0;
    {sgpio2_sclk_i, sgpio2_sload_i, sgpio2_sdout_i, sgpio3_sclk_i, sgpio3_sload_i,
     sgpio3_sdout_i, twb3_scl_low_i, twb3_sda_low_i, twb4_scl_low_i, twb4_sda_low_i} = 10'h0;
    wt(6);
    chk(fault_indicator_n_o, 17'h1_ffff);
    chk(oe, 8'hff);
    reset_i = 1'b0;
    $display("reset done");
    t_faults;
    t_sel(1'b1);
    t_sel(1'b0);
    close_out;
  end
endmodule // flsp_top_tb
`default_nettype wire
